/* cie_can_irq_err.v */
// can interrupt flags, error state, error counters and bit-timing register behind apb
//
// Decided for this implementation: register access over APB and the register addresses.
`include "cie_defs.vh"

module cie_flag_bit (
	input wire clk, // module clock
	input wire rst_n, // async reset, active low
	input wire set, // hardware event pulse
	input wire clr, // software clear pulse
	output reg flag // latched flag
);
	wire next_flag;

	// set has priority so an event in the clear cycle is kept
	assign next_flag = set | (flag & ~clr);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag <= 1'b0;
		end else begin
			flag <= next_flag;
		end
	end
endmodule // cie_flag_bit

module cie_err_counter #(
	parameter [8:0] MAX = 9'h0ff
) (
	input wire clk, // module clock
	input wire rst_n, // async reset, active low
	input wire clr, // counter reset after bus-off recovery
	input wire add_one, // error worth one
	input wire add_eight, // error worth eight
	input wire sub_one, // successful frame
	output reg [8:0] count // saturating error count
);
	reg [10:0] next_sum;
	reg [8:0] next_count;
	wire [10:0] step_up;

	// both weights may land in one cycle, so they are summed before the limit test
	assign step_up = (add_eight ? 11'h008 : 11'h000) + (add_one ? 11'h001 : 11'h000);

	always @* begin
		next_sum = {2'b00, count} + step_up;
		if (sub_one && (next_sum != 11'h000)) begin
			next_sum = next_sum - 11'h001;
		end
		// saturate rather than wrap: a wrap would drop a failing node back to active
		if (next_sum > {2'b00, MAX}) begin
			next_count = MAX;
		end else begin
			next_count = next_sum[8:0];
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 9'h000;
		end else if (clr) begin
			count <= 9'h000;
		end else begin
			count <= next_count;
		end
	end
endmodule // cie_err_counter

// Operation
// - status bit 13 reads high while transmitter is bus-off.
// - status bit 12 reads high while transmitter is error-passive.
// - status bit 11 reads high while receiver is error-passive.
// - status bit 10 reads high while transmitter is at warning level.
// - status bit 9 reads high while receiver is at warning level.
// - status bit 8 is the OR of both warning conditions.
// - error flag bit 5 sets when any status condition 13..8 arises.
// - flag bit 7 sets on an invalid received message.
// - flag bit 6 sets on bus wake-up activity.
// - flag bit 3 sets when receive queue reaches almost full.
// - flag bit 2 sets when a message overflows receive buffers.
// - flag bit 1 sets when a receive buffer gets a message.
// - flag bit 0 sets on a transmit buffer event.
// - enable bits at flag positions, reset zero, gate flags into interrupt.
// - enable bit 6 gates the wake-up flag into the interrupt.
// - transmit error count, read-only, reset zero, in bits 15..8.
// - receive error count, read-only, reset zero, in bits 7..0.
// - unimplemented bits read as zero.
module cie_can_irq_err (
	input wire pclk, // apb and module clock
	input wire presetn, // async reset, active low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb direction, high for write
	input wire [11:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	input wire [3:0] pstrb, // apb write byte strobes
	output reg [31:0] prdata, // apb read data
	output reg pready, // apb ready
	output reg pslverr, // apb error, unmapped address
	input wire ev_invalid_msg, // pulse: invalid message received
	input wire ev_wakeup, // pulse: wake-up activity seen
	input wire ev_queue_almost_full, // pulse: receive queue almost full
	input wire ev_rx_overflow, // pulse: receive buffer overflow
	input wire ev_rx_buffer, // pulse: receive buffer loaded
	input wire ev_tx_buffer, // pulse: transmit buffer event
	input wire tx_err_add8, // pulse: transmit error, +8
	input wire tx_err_sub1, // pulse: transmit success, -1
	input wire rx_err_add1, // pulse: receive error, +1
	input wire rx_err_add8, // pulse: receive error, +8
	input wire rx_err_sub1, // pulse: receive success, -1
	input wire err_count_clear, // pulse: bus-off recovery done, clears counts
	output reg can_irq, // module interrupt request
	output reg tx_bus_off, // transmitter bus-off
	output reg tx_err_passive, // transmitter error-passive
	output reg rx_err_passive, // receiver error-passive
	output reg [1:0] resync_jump_width, // jump width field
	output reg [5:0] quantum_prescaler // time quantum prescaler field
);
	wire [8:0] tx_error_counter;
	wire [8:0] rx_error_counter;
	wire [7:0] flags;
	wire [7:0] flag_set;
	wire [7:0] flag_clr;
	wire [7:0] tx_shown;
	reg [5:0] status;
	reg [5:0] next_status;
	reg [7:0] irq_en;
	reg [31:0] next_prdata;
	reg next_slverr;
	wire setup_phase;
	wire wr_en;
	wire low_lane;
	wire err_rise;
	wire sel_flags;
	wire sel_enables;
	wire sel_bit_timing;
	wire tx_add8_live;
	wire tx_sub1_live;
	wire [7:0] irq_pending;
	wire [7:0] next_irq_en;

	assign setup_phase = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite;
	assign low_lane = pstrb[0];

	// one compare per register, shared by the write and clear decode
	assign sel_flags = (paddr == `CIE_OFF_FLAGS);
	assign sel_enables = (paddr == `CIE_OFF_ENABLES);
	assign sel_bit_timing = (paddr == `CIE_OFF_BIT_TIMING);

	// bus-off freezes the tx count until recovery clears it
	assign tx_add8_live = tx_err_add8 & ~status[`CIE_ST_TX_BUS_OFF];
	assign tx_sub1_live = tx_err_sub1 & ~status[`CIE_ST_TX_BUS_OFF];

	cie_err_counter #(
		.MAX(`CIE_BUS_OFF_LIMIT)
	) u_tx_cnt (
		.clk(pclk),
		.rst_n(presetn),
		.clr(err_count_clear),
		.add_one(1'b0),
		.add_eight(tx_add8_live),
		.sub_one(tx_sub1_live),
		.count(tx_error_counter)
	);

	cie_err_counter #(
		.MAX(`CIE_RX_MAX)
	) u_rx_cnt (
		.clk(pclk),
		.rst_n(presetn),
		.clr(err_count_clear),
		.add_one(rx_err_add1),
		.add_eight(rx_err_add8),
		.sub_one(rx_err_sub1),
		.count(rx_error_counter)
	);

	always @* begin
		next_status = `CIE_RST_STATUS;
		next_status[`CIE_ST_TX_BUS_OFF] = (tx_error_counter >= `CIE_BUS_OFF_LIMIT);
		next_status[`CIE_ST_TX_PASSIVE] = (tx_error_counter >= `CIE_PASSIVE_LIMIT)
			&& (tx_error_counter < `CIE_BUS_OFF_LIMIT);
		next_status[`CIE_ST_RX_PASSIVE] = (rx_error_counter >= `CIE_PASSIVE_LIMIT);
		next_status[`CIE_ST_TX_WARN] = (tx_error_counter >= `CIE_WARN_LIMIT);
		next_status[`CIE_ST_RX_WARN] = (rx_error_counter >= `CIE_WARN_LIMIT);
		next_status[`CIE_ST_ANY_WARN] = next_status[`CIE_ST_TX_WARN]
			| next_status[`CIE_ST_RX_WARN];
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= `CIE_RST_STATUS;
		end else begin
			status <= next_status;
		end
	end

	// pin copies have their own flops so the outputs stay registered
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_bus_off <= 1'b0;
			tx_err_passive <= 1'b0;
			rx_err_passive <= 1'b0;
		end else begin
			tx_bus_off <= next_status[`CIE_ST_TX_BUS_OFF];
			tx_err_passive <= next_status[`CIE_ST_TX_PASSIVE];
			rx_err_passive <= next_status[`CIE_ST_RX_PASSIVE];
		end
	end

	// only a newly entered state raises the error flag, not one that persists
	assign err_rise = |(next_status & ~status);

	assign flag_set[`CIE_BIT_INVALID_MSG] = ev_invalid_msg;
	assign flag_set[`CIE_BIT_WAKEUP] = ev_wakeup;
	assign flag_set[`CIE_BIT_ERROR] = err_rise;
	assign flag_set[`CIE_BIT_UNUSED] = 1'b0;
	assign flag_set[`CIE_BIT_QUEUE_FULL] = ev_queue_almost_full;
	assign flag_set[`CIE_BIT_RX_OVERFLOW] = ev_rx_overflow;
	assign flag_set[`CIE_BIT_RX_BUFFER] = ev_rx_buffer;
	assign flag_set[`CIE_BIT_TX_BUFFER] = ev_tx_buffer;

	// writing zero clears, writing one leaves the flag alone
	assign flag_clr = (wr_en && low_lane && sel_flags) ? ~pwdata[7:0] : 8'h00;

	cie_flag_bit u_flag_invalid_msg (
		.clk(pclk),
		.rst_n(presetn),
		.set(flag_set[`CIE_BIT_INVALID_MSG]),
		.clr(flag_clr[`CIE_BIT_INVALID_MSG]),
		.flag(flags[`CIE_BIT_INVALID_MSG])
	);

	cie_flag_bit u_flag_wakeup (
		.clk(pclk),
		.rst_n(presetn),
		.set(flag_set[`CIE_BIT_WAKEUP]),
		.clr(flag_clr[`CIE_BIT_WAKEUP]),
		.flag(flags[`CIE_BIT_WAKEUP])
	);

	cie_flag_bit u_flag_error (
		.clk(pclk),
		.rst_n(presetn),
		.set(flag_set[`CIE_BIT_ERROR]),
		.clr(flag_clr[`CIE_BIT_ERROR]),
		.flag(flags[`CIE_BIT_ERROR])
	);

	cie_flag_bit u_flag_queue_full (
		.clk(pclk),
		.rst_n(presetn),
		.set(flag_set[`CIE_BIT_QUEUE_FULL]),
		.clr(flag_clr[`CIE_BIT_QUEUE_FULL]),
		.flag(flags[`CIE_BIT_QUEUE_FULL])
	);

	cie_flag_bit u_flag_rx_overflow (
		.clk(pclk),
		.rst_n(presetn),
		.set(flag_set[`CIE_BIT_RX_OVERFLOW]),
		.clr(flag_clr[`CIE_BIT_RX_OVERFLOW]),
		.flag(flags[`CIE_BIT_RX_OVERFLOW])
	);

	cie_flag_bit u_flag_rx_buffer (
		.clk(pclk),
		.rst_n(presetn),
		.set(flag_set[`CIE_BIT_RX_BUFFER]),
		.clr(flag_clr[`CIE_BIT_RX_BUFFER]),
		.flag(flags[`CIE_BIT_RX_BUFFER])
	);

	cie_flag_bit u_flag_tx_buffer (
		.clk(pclk),
		.rst_n(presetn),
		.set(flag_set[`CIE_BIT_TX_BUFFER]),
		.clr(flag_clr[`CIE_BIT_TX_BUFFER]),
		.flag(flags[`CIE_BIT_TX_BUFFER])
	);

	// the unimplemented position has no flop at all
	assign flags[`CIE_BIT_UNUSED] = 1'b0;

	assign next_irq_en = pwdata[7:0] & `CIE_FLAG_MASK;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en <= `CIE_RST_BYTE;
		end else if (wr_en && low_lane && sel_enables) begin
			irq_en <= next_irq_en;
		end
	end

	// these fields feed the bit timer outside this block and also read back over apb
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resync_jump_width <= 2'h0;
			quantum_prescaler <= 6'h00;
		end else if (wr_en && low_lane && sel_bit_timing) begin
			resync_jump_width <= pwdata[`CIE_BT_SJW_MSB:`CIE_BT_SJW_LSB];
			quantum_prescaler <= pwdata[`CIE_BT_BRP_MSB:`CIE_BT_BRP_LSB];
		end
	end

	assign irq_pending = flags & irq_en;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			can_irq <= 1'b0;
		end else begin
			can_irq <= |irq_pending;
		end
	end

	// a bus-off count of 256 has no 8-bit form, so it reads as full scale
	assign tx_shown = tx_error_counter[8] ? `CIE_TX_SHOWN_MAX : tx_error_counter[7:0];

	always @* begin
		next_prdata = `CIE_RST_WORD;
		next_slverr = 1'b0;
		case (paddr)
			`CIE_OFF_FLAGS: begin
				next_prdata[13:8] = status;
				next_prdata[7:0] = flags;
			end
			`CIE_OFF_ENABLES: begin
				next_prdata[7:0] = irq_en;
			end
			`CIE_OFF_ERR_COUNT: begin
				next_prdata[`CIE_EC_TX_MSB:`CIE_EC_TX_LSB] = tx_shown;
				next_prdata[`CIE_EC_RX_MSB:`CIE_EC_RX_LSB] = rx_error_counter[7:0];
			end
			`CIE_OFF_BIT_TIMING: begin
				next_prdata[`CIE_BT_SJW_MSB:`CIE_BT_SJW_LSB] = resync_jump_width;
				next_prdata[`CIE_BT_BRP_MSB:`CIE_BT_BRP_LSB] = quantum_prescaler;
			end
			default: begin
				next_slverr = 1'b1;
			end
		endcase
	end

	// one registered stage: ready rises with the first access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_phase;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup_phase & next_slverr;
		end
	end

	// zero while idle so a later read never shows a stale word
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `CIE_RST_WORD;
		end else if (setup_phase && !pwrite) begin
			prdata <= next_prdata;
		end else if (!psel) begin
			prdata <= `CIE_RST_WORD;
		end
	end
endmodule // cie_can_irq_err

/* cie_defs.vh */
// constants for the can interrupt, error status and bit-timing register block
`ifndef CIE_DEFS_VH
`define CIE_DEFS_VH

// apb byte addresses
`define CIE_ADDR_W 12
`define CIE_OFF_FLAGS 12'h000
`define CIE_OFF_ENABLES 12'h004
`define CIE_OFF_ERR_COUNT 12'h008
`define CIE_OFF_BIT_TIMING 12'h00c

// interrupt flag / enable positions (low byte)
`define CIE_BIT_INVALID_MSG 7
`define CIE_BIT_WAKEUP 6
`define CIE_BIT_ERROR 5
`define CIE_BIT_QUEUE_FULL 3
`define CIE_BIT_RX_OVERFLOW 2
`define CIE_BIT_RX_BUFFER 1
`define CIE_BIT_TX_BUFFER 0
`define CIE_BIT_UNUSED 4
`define CIE_FLAG_MASK 8'hef

// status positions inside the 6-bit status field (flag register bits 13..8)
`define CIE_ST_TX_BUS_OFF 5
`define CIE_ST_TX_PASSIVE 4
`define CIE_ST_RX_PASSIVE 3
`define CIE_ST_TX_WARN 2
`define CIE_ST_RX_WARN 1
`define CIE_ST_ANY_WARN 0

// error count register fields
`define CIE_EC_TX_MSB 15
`define CIE_EC_TX_LSB 8
`define CIE_EC_RX_MSB 7
`define CIE_EC_RX_LSB 0

// bit-timing register fields
`define CIE_BT_SJW_MSB 7
`define CIE_BT_SJW_LSB 6
`define CIE_BT_BRP_MSB 5
`define CIE_BT_BRP_LSB 0

// fault confinement thresholds, compared against the 9-bit tx and rx counts
`define CIE_WARN_LIMIT 9'h060
`define CIE_PASSIVE_LIMIT 9'h080
`define CIE_BUS_OFF_LIMIT 9'h100
`define CIE_RX_MAX 9'h0ff
`define CIE_TX_SHOWN_MAX 8'hff

// reset values
`define CIE_RST_BYTE 8'h00
`define CIE_RST_STATUS 6'h00
`define CIE_RST_WORD 32'h0000_0000

`endif

/* cie_can_irq_err_monitor.sv */
// assertions on the apb handshake and transmitter fault state
module cie_can_irq_err_monitor (
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic psel, // select
	input wire logic penable, // access
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic tx_err_add8, // tx error
	input wire logic err_count_clear, // clear
	input wire logic tx_bus_off, // bus-off
	input wire logic tx_err_passive // passive
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_once_a: assert property (pready |=> !pready)
		else $error("ready held");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0)
		else $error("upper bits set");
	idle_data_a: assert property (!psel |=> prdata == 32'h0)
		else $error("stale read data");
	busoff_excl_a: assert property (tx_bus_off |-> !tx_err_passive)
		else $error("passive during bus-off");
	busoff_hold_a: assert property (tx_bus_off && !$past(err_count_clear)
		&& !err_count_clear |=> tx_bus_off) else $error("bus-off left early");
	tx_passive_a: assert property ($rose(tx_err_passive) |-> $past(tx_err_add8, 2))
		else $error("passive without error");
endmodule // cie_can_irq_err_monitor

/* cie_bus_node.sv */
// far-side node model: turns bench requests into one-cycle event and error pulses
module cie_bus_node (
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic [13:0] req, // requested pulses
	output logic [13:0] pulse // pulses to the block
);
	timeunit 1ns;
	timeprecision 1ns;
	// registered so each pulse starts just after an edge, like same-clock logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pulse <= 14'h0;
		else
			pulse <= req;
	end
endmodule // cie_bus_node

/* tb_top.sv */
// self-checking bench: apb register traffic and far-side events
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [3:0] pstrb = 4'hf;
	logic can_irq, tx_bus_off, tx_err_passive, rx_err_passive;
	logic [1:0] resync_jump_width;
	logic [5:0] quantum_prescaler;
	logic [13:0] req = 14'h0, pulse;
	int err_count = 0, comparisons = 0;
	int kinds[6] = '{0, 1, 2, 3, 6, 7};
	initial begin
		forever #5 pclk = ~pclk;
	end
	cie_bus_node i_node (.pclk, .presetn, .req, .pulse);
	cie_can_irq_err i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .ev_invalid_msg(pulse[7]), .ev_wakeup(pulse[6]),
		.ev_queue_almost_full(pulse[3]), .ev_rx_overflow(pulse[2]), .ev_rx_buffer(pulse[1]),
		.ev_tx_buffer(pulse[0]), .tx_err_add8(pulse[8]), .tx_err_sub1(pulse[9]),
		.rx_err_add1(pulse[10]), .rx_err_add8(pulse[11]), .rx_err_sub1(pulse[12]),
		.err_count_clear(pulse[13]), .can_irq, .tx_bus_off, .tx_err_passive, .rx_err_passive,
		.resync_jump_width, .quantum_prescaler);
	task automatic finish_test();
		if (err_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// starts one edge late so psel never falls and rises in the same step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			check(32'h0, 32'h1);
			finish_test();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		check(rdat, e);
	endtask
	// status lags a count change by one edge and irq by two, hence the tail wait
	task automatic ev(input int k, input int n);
		repeat (n) begin
			@(posedge pclk);
			req <= 14'h1 << k;
			@(posedge pclk);
			req <= 14'h0;
		end
		repeat (2) @(posedge pclk);
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		for (int a = 0; a < 16; a += 4)
			rd(a[11:0], 32'h0);
		apb(1'h1, 12'h00c, 32'hffff_ffff);
		rd(12'h00c, 32'h0000_00ff);
		check({resync_jump_width, quantum_prescaler}, 32'h0ff);
		apb(1'h1, 12'h004, 32'hffff_ffff);
		rd(12'h004, 32'h0000_00ef);
		foreach (kinds[i]) begin
			ev(kinds[i], 1);
			apb(1'h1, 12'h000, 32'hffff_ffff);
			rd(12'h000, 32'h1 << kinds[i]);
			check(can_irq, 32'h1);
			apb(1'h1, 12'h000, 32'h0);
			rd(12'h000, 32'h0);
			check(can_irq, 32'h0);
		end
		apb(1'h1, 12'h004, 32'h0000_00af);
		ev(6, 1);
		check(can_irq, 32'h0);
		fork
			ev(1, 1);
			apb(1'h1, 12'h000, 32'h0);
		join
		rd(12'h000, 32'h0000_0002);
		apb(1'h1, 12'h000, 32'h0);
		ev(11, 11);
		ev(10, 8);
		rd(12'h008, 32'h0000_0060);
		rd(12'h000, 32'h0000_0320);
		check(can_irq, 32'h1);
		ev(11, 4);
		rd(12'h000, 32'h0000_0b20);
		check(rx_err_passive, 32'h1);
		ev(12, 1);
		rd(12'h000, 32'h0000_0320);
		ev(8, 12);
		rd(12'h000, 32'h0000_0720);
		ev(8, 4);
		rd(12'h000, 32'h0000_1720);
		check(tx_err_passive, 32'h1);
		ev(8, 16);
		ev(9, 1);
		apb(1'h1, 12'h008, 32'h0);
		rd(12'h008, 32'h0000_ff7f);
		rd(12'h000, 32'h0000_2720);
		check(tx_bus_off, 32'h1);
		ev(13, 1);
		rd(12'h008, 32'h0);
		rd(12'h000, 32'h0000_0020);
		rd(12'h010, 32'h0);
		check(rerr, 32'h1);
		finish_test();
	end
endmodule // tb_top

bind cie_can_irq_err cie_can_irq_err_monitor i_mon (.pclk, .presetn, .psel, .penable, .prdata,
	.pready, .pslverr, .tx_err_add8, .err_count_clear, .tx_bus_off, .tx_err_passive);
